// ### verilog/lfc_consts.svh
// Purpose: named offsets, field positions and reset values of the link format register
// Assumes: 8-bit register port, 8-bit register addresses
// Notes: definitions only
`ifndef LFC_CONSTS_SVH
`define LFC_CONSTS_SVH

// ----------------------------------------
// addresses
// ----------------------------------------
`define LFC_ADDR_W 8
`define LFC_DATA_W 8
`define LFC_ADDR_RSVD 8'h06
`define LFC_ADDR_FMT 8'h07

// ----------------------------------------
// reset values
// ----------------------------------------
`define LFC_RSVD_VALUE 8'h02
`define LFC_FMT_RESET 8'h00
`define LFC_UNMAPPED_VALUE 8'h00

// ----------------------------------------
// field positions in the format register
// ----------------------------------------
`define LFC_BIT_DOUBLE 7
`define LFC_BIT_RATE 6
`define LFC_BIT_WIDE 5
`define LFC_BIT_EDGE 4
`define LFC_BIT_TRACK 3
`define LFC_BIT_ENC 2
`define LFC_CODE_HI 1
`define LFC_CODE_LO 0

// ----------------------------------------
// check code encodings
// ----------------------------------------
`define LFC_CODE_PARITY 2'h0
`define LFC_CODE_CRC 2'h1
`define LFC_CODE_HAMMING 2'h2
`define LFC_CODE_BAD 2'h3

// ----------------------------------------
// pin synchroniser depth
// ----------------------------------------
`define LFC_SYNC_STAGES 2

`endif

// ### verilog/lfc_pkg.sv
// Purpose: types shared by the link format configuration block
// Assumes: constants come from lfc_consts.svh
// Notes: struct field order matches the register bit order
`include "lfc_consts.svh"

package lfc_pkg;

  // ----------------------------------------
  // check code selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    LFC_PARITY = `LFC_CODE_PARITY,
    LFC_CRC = `LFC_CODE_CRC,
    LFC_HAMMING = `LFC_CODE_HAMMING,
    LFC_BAD = `LFC_CODE_BAD
  } lfc_code_t;

  // ----------------------------------------
  // format register image, msb first
  // ----------------------------------------
  typedef struct packed {
    logic double_pixel_mode;
    logic low_rate_select;
    logic wide_word_select;
    logic output_edge_select;
    logic sync_tracking_on;
    logic sync_encode_on;
    lfc_code_t check_code_select;
  } lfc_cfg_t;

  // ----------------------------------------
  // strap pins
  // ----------------------------------------
  typedef struct packed {
    logic local_ctrl_enable_pin;
    logic double_strap_pin;
    logic width_strap_pin;
    logic edge_strap_pin;
    logic sync_strap_pin;
    logic check_code_strap_pin;
  } lfc_straps_t;

  // ----------------------------------------
  // register port request
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`LFC_ADDR_W-1:0] addr;
    logic [`LFC_DATA_W-1:0] wdata;
  } lfc_req_t;

  // ----------------------------------------
  // decoded check engine enables
  // ----------------------------------------
  typedef struct packed {
    logic parity_on;
    logic crc_on;
    logic hamming_on;
  } lfc_check_t;

endpackage

// ### verilog/lfc_top.sv
// Purpose: link format configuration register of a serial video deserializer
// Assumes: register accesses arrive already decoded from the control channel
// Notes: strap pins are synchronised and captured on the first edge after reset release
`timescale 1ns/10ps
`include "lfc_consts.svh"

// What this block does
// RULE_01: bit 7 picks single or double pixel
// RULE_02: bit 5 picks 24 or 32 bit words
// RULE_03: bit 4 picks the output data edge
// RULE_04: edge bit defaults from strap when enabled
// RULE_05: software changes edge bit only while stopped
// RULE_06: bit 3 enables sync tracking, strap default
// RULE_07: bit 2 enables sync encoding, strap default
// RULE_08: code 00 selects single-bit parity check
// RULE_09: code 01 selects six-bit crc check
// RULE_10: code 10 selects hamming; 11 never used
// RULE_11: code defaults 10 from strap, else 00
// RULE_12: bit 6 picks rate range, resets zero
module lfc_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire lfc_pkg::lfc_straps_t i_straps,
  input wire logic i_pixel_clock_running,
  input wire lfc_pkg::lfc_req_t i_req,
  output logic [`LFC_DATA_W-1:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_reg_refused,
  output logic o_cfg_valid,
  output lfc_pkg::lfc_cfg_t o_cfg,
  output lfc_pkg::lfc_check_t o_check
);
  import lfc_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  lfc_straps_t strap_meta;
  lfc_straps_t strap_sync;
  logic run_meta;
  logic run_sync;
  logic strap_load;
  lfc_cfg_t cfg;
  lfc_cfg_t next_cfg;
  lfc_cfg_t strap_cfg;
  logic fmt_wr;
  logic fmt_rd;
  logic rsvd_rd;
  logic write_refused;
  lfc_cfg_t wr_img;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // one-hot engine enables for codes 00 to 10; code 11 enables none
  function automatic lfc_check_t decode_code(input lfc_code_t code);
    lfc_check_t d;
    d = '0;
    case (code)
      LFC_PARITY: begin
        d.parity_on = 1'b1; // RULE_08
      end
      LFC_CRC: begin
        d.crc_on = 1'b1; // RULE_09
      end
      LFC_HAMMING: begin
        d.hamming_on = 1'b1; // RULE_10
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  // a strap only counts while local control is pulled low
  function automatic logic strap_bit(input logic lcc_pin, input logic pin);
    return ~lcc_pin & pin;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // no reset here so straps are settled by the time reset releases
  always_ff @(posedge i_clk) begin
    strap_meta <= i_straps;
    strap_sync <= strap_meta;
  end

  always_ff @(posedge i_clk) begin
    run_meta <= i_pixel_clock_running;
    run_sync <= run_meta;
  end

  // ----------------------------------------
  // strap defaults
  // ----------------------------------------
  always_comb begin
    strap_cfg = '0;
    strap_cfg.double_pixel_mode =
      strap_bit(strap_sync.local_ctrl_enable_pin, strap_sync.double_strap_pin); // RULE_01
    strap_cfg.low_rate_select = 1'b0; // RULE_12
    strap_cfg.wide_word_select =
      strap_bit(strap_sync.local_ctrl_enable_pin, strap_sync.width_strap_pin); // RULE_02
    strap_cfg.output_edge_select =
      strap_bit(strap_sync.local_ctrl_enable_pin, strap_sync.edge_strap_pin); // RULE_04
    strap_cfg.sync_tracking_on =
      strap_bit(strap_sync.local_ctrl_enable_pin, strap_sync.sync_strap_pin); // RULE_06
    strap_cfg.sync_encode_on =
      strap_bit(strap_sync.local_ctrl_enable_pin, strap_sync.sync_strap_pin); // RULE_07
    if (strap_bit(strap_sync.local_ctrl_enable_pin, strap_sync.check_code_strap_pin)) begin
      strap_cfg.check_code_select = LFC_HAMMING; // RULE_11
    end else begin
      strap_cfg.check_code_select = LFC_PARITY; // RULE_11
    end
  end

  // ----------------------------------------
  // capture straps after reset release
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strap_load <= 1'b1;
    end else begin
      strap_load <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cfg_valid <= 1'b0;
    end else if (strap_load) begin
      o_cfg_valid <= 1'b1;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // accesses in the strap capture cycle are ignored and not acknowledged, straps win
  assign fmt_wr = i_req.wr & ~strap_load & (i_req.addr == `LFC_ADDR_FMT);
  assign fmt_rd = i_req.rd & ~strap_load & (i_req.addr == `LFC_ADDR_FMT);
  assign rsvd_rd = i_req.rd & ~strap_load & (i_req.addr == `LFC_ADDR_RSVD);
  assign wr_img = lfc_cfg_t'(i_req.wdata);

  // ----------------------------------------
  // next register value
  // ----------------------------------------
  always_comb begin
    next_cfg = cfg;
    write_refused = 1'b0;
    if (strap_load) begin
      next_cfg = strap_cfg;
    end else if (fmt_wr) begin
      next_cfg.double_pixel_mode = wr_img.double_pixel_mode; // RULE_01
      next_cfg.low_rate_select = wr_img.low_rate_select; // RULE_12
      next_cfg.wide_word_select = wr_img.wide_word_select; // RULE_02
      next_cfg.sync_tracking_on = wr_img.sync_tracking_on; // RULE_06
      next_cfg.sync_encode_on = wr_img.sync_encode_on; // RULE_07
      // edge change while pixel clock runs would glitch outputs; hold it
      if (run_sync && (wr_img.output_edge_select != cfg.output_edge_select)) begin
        write_refused = 1'b1; // RULE_05
      end else begin
        next_cfg.output_edge_select = wr_img.output_edge_select; // RULE_03
      end
      // the unused code is dropped so a valid checker stays selected
      if (wr_img.check_code_select == LFC_BAD) begin
        write_refused = 1'b1; // RULE_10
      end else begin
        next_cfg.check_code_select = wr_img.check_code_select; // RULE_08
      end
    end
  end

  // ----------------------------------------
  // format register
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg <= lfc_cfg_t'(`LFC_FMT_RESET);
    end else begin
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cfg <= lfc_cfg_t'(`LFC_FMT_RESET);
    end else begin
      o_cfg <= next_cfg; // RULE_03
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_check <= decode_code(LFC_PARITY);
    end else begin
      o_check <= decode_code(next_cfg.check_code_select); // RULE_09
    end
  end

  // ----------------------------------------
  // register port answers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= (i_req.wr | i_req.rd) & ~strap_load;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_refused <= 1'b0;
    end else begin
      o_reg_refused <= write_refused;
    end
  end

  // reserved register is fixed; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= `LFC_UNMAPPED_VALUE;
    end else if (fmt_rd) begin
      o_reg_rdata <= cfg;
    end else if (rsvd_rd) begin
      o_reg_rdata <= `LFC_RSVD_VALUE;
    end else if (i_req.rd && !strap_load) begin
      o_reg_rdata <= `LFC_UNMAPPED_VALUE;
    end
  end

endmodule // lfc_top

// ### tb/lfc_top_props.sv
// Purpose: checker for the link format register outputs
// Assumes: straps steady across each reset
// Notes: bound from the testbench top file
`timescale 1ns/10ps
`include "lfc_consts.svh"
module lfc_top_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire lfc_pkg::lfc_straps_t i_straps,
  input wire logic i_pixel_clock_running,
  input wire lfc_pkg::lfc_req_t i_req,
  input wire logic [`LFC_DATA_W-1:0] o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic o_reg_refused,
  input wire logic o_cfg_valid,
  input wire lfc_pkg::lfc_cfg_t o_cfg,
  input wire lfc_pkg::lfc_check_t o_check
);
  import lfc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic lcc_n;
  logic [7:0] img;
  logic [7:0] img_d1, img_d2, img_d3;
  assign lcc_n = ~i_straps.local_ctrl_enable_pin;
  assign img = {lcc_n & i_straps.double_strap_pin, 1'b0, lcc_n & i_straps.width_strap_pin,
    lcc_n & i_straps.edge_strap_pin, {2{lcc_n & i_straps.sync_strap_pin}},
    lcc_n & i_straps.check_code_strap_pin, 1'b0};
  // three stages cover the pin synchroniser plus the capture edge
  always_ff @(posedge i_clk) begin
    img_d1 <= img;
    img_d2 <= img_d1;
    img_d3 <= img_d2;
  end
  sequence s_load;
    $rose(o_cfg_valid);
  endsequence
  AST_LOAD_DBL: assert property (s_load |-> o_cfg.double_pixel_mode == img_d3[7])
    else $error("double pixel strap default wrong");
  AST_LOAD_RATE: assert property (s_load |-> !o_cfg.low_rate_select)
    else $error("rate default not zero");
  AST_LOAD_WIDE: assert property (s_load |-> o_cfg.wide_word_select == img_d3[5])
    else $error("word width strap default wrong");
  AST_LOAD_EDGE: assert property (s_load |-> o_cfg.output_edge_select == img_d3[4])
    else $error("edge strap default wrong");
  AST_LOAD_SYNC: assert property (s_load |->
    {o_cfg.sync_tracking_on, o_cfg.sync_encode_on} == img_d3[3:2])
    else $error("sync strap default wrong");
  AST_LOAD_CODE: assert property (s_load |-> o_cfg.check_code_select == img_d3[1:0])
    else $error("check code strap default wrong");
  AST_DECODE: assert property (o_check == {o_cfg.check_code_select == LFC_PARITY,
    o_cfg.check_code_select == LFC_CRC, o_cfg.check_code_select == LFC_HAMMING})
    else $error("check engine enables disagree with code");
  AST_NO_BAD: assert property (o_cfg.check_code_select != LFC_BAD)
    else $error("forbidden check code stored");
  AST_WRITE: assert property (o_cfg_valid && i_req.wr && i_req.addr == `LFC_ADDR_FMT
    && i_req.wdata[1:0] != `LFC_CODE_BAD
    && i_req.wdata[4] == o_cfg.output_edge_select |=> o_cfg == $past(i_req.wdata))
    else $error("format write not applied");
endmodule // lfc_top_props

// ### tb/lfc_host.sv
// Purpose: control channel master stand-in
// Assumes: one access at a time
// Notes: drives on falling edges, one-cycle request
`timescale 1ns/10ps
`include "lfc_consts.svh"
module lfc_host (
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [`LFC_DATA_W-1:0] i_rdata,
  input wire logic i_refused,
  output lfc_pkg::lfc_req_t o_req
);
  import lfc_pkg::*;
  initial o_req = '0;
  // request held over one rising edge, answer taken the edge after
  task automatic acc(input logic w, r, input logic [7:0] a, d, output logic [7:0] q, output logic ak, rf);
    @(negedge i_clk);
    o_req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge i_clk);
    q = i_rdata;
    ak = i_ack;
    rf = i_refused;
    o_req = '0;
  endtask
endmodule // lfc_host

// ### tb/tb_link_format_config.sv
// Purpose: register level test of the link format block
// Assumes: host model issues all accesses
// Notes: straps change only inside reset
`timescale 1ns/10ps
`include "lfc_consts.svh"
module tb_link_format_config;
  import lfc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic run = 1'b0;
  lfc_straps_t straps = '0;
  lfc_req_t req;
  logic [7:0] rdata;
  logic ack, refused, valid;
  lfc_cfg_t cfg;
  lfc_check_t chk3;
  int failures = 0;
  int tests_run = 0;
  logic [7:0] q;
  logic ak, rf;
  always #12.5 i_clk = ~i_clk;
  lfc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_straps(straps), .i_pixel_clock_running(run), .i_req(req),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .o_reg_refused(refused), .o_cfg_valid(valid), .o_cfg(cfg),
    .o_check(chk3));
  lfc_host host (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata), .i_refused(refused), .o_req(req));
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic boot(input lfc_straps_t s, input logic [7:0] exp);
    @(negedge i_clk);
    i_rst = 1'b1;
    straps = s;
    repeat (10) @(negedge i_clk);
    check("reset valid", {7'h0, valid}, 8'h00);
    check("reset cfg", cfg, `LFC_FMT_RESET);
    check("reset check", {5'h0, chk3}, 8'h04);
    i_rst = 1'b0;
    @(negedge i_clk);
    check("valid", {7'h0, valid}, 8'h01);
    check("cfg", cfg, exp);
  endtask
  task automatic wr(input logic [7:0] a, d, exp_cfg, input logic exp_rf);
    host.acc(1'b1, 1'b0, a, d, q, ak, rf);
    check("ack", {7'h0, ak}, 8'h01);
    check("refused", {7'h0, rf}, {7'h0, exp_rf});
    check("cfg", cfg, exp_cfg);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    host.acc(1'b0, 1'b1, a, 8'h00, q, ak, rf);
    check("ack", {7'h0, ak}, 8'h01);
    check("rdata", q, exp);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    boot(6'h1f, 8'hbe);
    boot(6'h3f, 8'h00);
    boot(6'h14, 8'h90);
    boot(6'h0b, 8'h2e);
    boot(6'h00, 8'h00);
    rd(8'h06, 8'h02);
    wr(8'h06, 8'hff, 8'h00, 1'b0);
    rd(8'h06, 8'h02);
    rd(8'h10, 8'h00);
    wr(8'h07, 8'ha2, 8'ha2, 1'b0);
    rd(8'h07, 8'ha2);
    for (int c = 0; c < 3; c++) begin
      wr(8'h07, {6'h2b, c[1:0]}, {6'h2b, c[1:0]}, 1'b0);
      check("check", {5'h0, chk3}, 8'h04 >> c);
    end
    // 11 is dropped; the edge bit still moves because the clock is stopped
    wr(8'h07, 8'hff, 8'hfe, 1'b1);
    run = 1'b1;
    repeat (4) @(negedge i_clk);
    wr(8'h07, 8'h41, 8'h51, 1'b1);
    wr(8'h07, 8'h12, 8'h12, 1'b0);
    run = 1'b0;
    repeat (4) @(negedge i_clk);
    wr(8'h07, 8'h02, 8'h02, 1'b0);
    rd(8'h07, 8'h02);
    end_of_test();
  end
  initial begin
    repeat (2000) @(posedge i_clk);
    failures++;
    end_of_test();
  end
endmodule // tb_link_format_config
bind lfc_top lfc_top_props props (.i_clk(i_clk), .i_rst(i_rst), .i_straps(i_straps),
  .i_pixel_clock_running(i_pixel_clock_running), .i_req(i_req), .o_reg_rdata(o_reg_rdata),
  .o_reg_ack(o_reg_ack), .o_reg_refused(o_reg_refused), .o_cfg_valid(o_cfg_valid), .o_cfg(o_cfg),
  .o_check(o_check));
